// *** src/serial_eeprom_read_engine.sv ***
// two-wire serial memory slave, read side
//
// Overview of operation
// - a read starts like a write, direction bit of device byte is one
// - address counter holds last accessed address plus one
// - counter keeps its value between transactions
// - counter wraps from last byte to first byte, read continues
// - after acking a read address, shift out byte at counter address
// - after repeated start, ack read address, send byte at loaded address
// - sequential read begins as current or random read, host acks to go on
// - each host ack increments address and sends next byte; stop after nack
// - protect status query uses programming sequence with direction bit 1
// - permanent query: ack if flag clear, no ack if programmed
// - reversible query: ack if flag clear, no ack if programmed
`timescale 1ns/1ps
`include "eeprom_rd_regs.svh"
module serial_eeprom_read_engine (
  // clock and reset
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_reset_n,
  // serial bus pins
  input  wire logic                  i_scl,
  input  wire logic                  i_sda,
  output logic                       o_sda_out,
  output logic                       o_sda_oe,
  // chip select pins
  input  wire logic                  i_chip_select_bit2,
  input  wire logic                  i_chip_select_bit1,
  input  wire logic                  i_chip_select_bit0,
  // protect flags
  input  wire logic                  i_permanent_protect_flag,
  input  wire logic                  i_reversible_protect_flag,
  // array read port, data one cycle after o_mem_rd
  output eeprom_rd_pkg::addr_t       o_mem_addr,
  output logic                       o_mem_rd,
  input  wire eeprom_rd_pkg::byte_t  i_mem_data
);
  import eeprom_rd_pkg::*;

  // ************************************
  // pin synchronisers
  // ************************************
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic [1:0] prev_reg;
  logic       scl_s;
  logic       sda_s;
  cs_t        cs_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start;
  logic       stop;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1_reg <= 5'h1F;
      sync2_reg <= 5'h1F;
      prev_reg  <= 2'h3;
    end else begin
      sync1_reg <= {i_scl, i_sda, i_chip_select_bit2, i_chip_select_bit1, i_chip_select_bit0};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg[4:3];
    end
  end

  assign scl_s    = sync2_reg[4];
  assign sda_s    = sync2_reg[3];
  assign cs_s     = sync2_reg[2:0];
  assign scl_rise = scl_s && !prev_reg[1];
  assign scl_fall = !scl_s && prev_reg[1];
  assign start    = scl_s && prev_reg[1] && prev_reg[0] && !sda_s;
  assign stop     = scl_s && prev_reg[1] && !prev_reg[0] && sda_s;

  // ************************************
  // address byte decode
  // ************************************
  function automatic logic dev_match(input byte_t b, input cs_t cs, input logic [3:0] pre);
    dev_match = (b[7:4] == pre) && (b[3:1] == cs);
  endfunction

  // ************************************
  // protocol state
  // ************************************
  byte_fifo_if #(.WIDTH(`DATA_BITS)) fq ();

  state_e     state_reg;
  state_e     state_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  byte_t      shift_reg;
  byte_t      shift_next;
  byte_t      tx_reg;
  byte_t      tx_next;
  addr_t      addr_reg;
  addr_t      addr_next;
  logic       oe_reg;
  logic       oe_next;
  logic       ack_reg;
  logic       ack_next;
  logic       flush_reg;
  logic       flush_next;
  logic       sda_out_reg;
  logic       pop;
  logic [2:0] bit_idx;

  assign bit_idx = 3'(`BIT_TOP - cnt_reg);

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    shift_next = shift_reg;
    tx_next    = tx_reg;
    addr_next  = addr_reg;
    oe_next    = oe_reg;
    ack_next   = ack_reg;
    flush_next = 1'b0;
    pop        = 1'b0;
    if (start) begin
      state_next = ST_DEV;
      cnt_next   = '0;
      oe_next    = 1'b0;
    end else if (stop) begin
      state_next = ST_IDLE;
      oe_next    = 1'b0;
    end else begin
      case (state_reg)
        ST_DEV, ST_WORD, ST_WDATA: begin
          if (scl_rise && cnt_reg != `BYTE_BITS) begin
            shift_next = {shift_reg[6:0], sda_s};
            cnt_next   = 4'(cnt_reg + 1'b1);
          end else if (scl_fall && cnt_reg == `BYTE_BITS) begin
            cnt_next = '0;
            oe_next  = 1'b1;
            if (state_reg == ST_DEV) begin
              // direction bit picks read or write
              if (dev_match(shift_reg, cs_s, `DEV_PREAMBLE)) begin
                state_next = shift_reg[0] ? ST_RACK : ST_WACK;
              end else if (dev_match(shift_reg, cs_s, `PERM_QUERY_PRE) && shift_reg[0]) begin
                oe_next    = !i_permanent_protect_flag;
                state_next = i_permanent_protect_flag ? ST_WAIT : ST_QACK;
              end else if (dev_match(shift_reg, cs_s, `REV_QUERY_PRE) && shift_reg[0]) begin
                oe_next    = !i_reversible_protect_flag;
                state_next = i_reversible_protect_flag ? ST_WAIT : ST_QACK;
              end else begin
                oe_next    = 1'b0;
                state_next = ST_WAIT;
              end
            end else if (state_reg == ST_WORD) begin
              addr_next  = shift_reg;
              flush_next = 1'b1;
              state_next = ST_DACK;
            end else begin
              state_next = ST_DACK;
            end
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            oe_next    = 1'b0;
            state_next = ST_WORD;
          end
        end
        ST_DACK: begin
          if (scl_fall) begin
            oe_next    = 1'b0;
            state_next = ST_WDATA;
          end
        end
        ST_QACK: begin
          if (scl_fall) begin
            oe_next    = 1'b0;
            state_next = ST_WAIT;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt_reg == `BYTE_BITS) begin
              oe_next    = 1'b0;
              cnt_next   = '0;
              ack_next   = 1'b0;
              state_next = ST_HACK;
            end else begin
              oe_next  = !tx_reg[bit_idx];
              cnt_next = 4'(cnt_reg + 1'b1);
            end
          end
        end
        ST_HACK: begin
          // host ack low continues, high ends
          if (scl_rise) begin
            ack_next = !sda_s;
          end else if (scl_fall && !ack_reg) begin
            state_next = ST_WAIT;
          end
        end
        default: begin
        end
      endcase
      // load next byte and advance counter
      if (scl_fall && (state_reg == ST_RACK || (state_reg == ST_HACK && ack_reg))) begin
        pop        = 1'b1;
        tx_next    = fq.out_valid ? fq.out_data : `IDLE_BYTE;
        flush_next = !fq.out_valid;
        // plus one, wraps naturally at the top
        addr_next  = addr_t'(addr_reg + `ADDR_ONE);
        oe_next    = !tx_next[7];
        cnt_next   = 4'h1;
        state_next = ST_TX;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg   <= ST_IDLE;
      cnt_reg     <= '0;
      shift_reg   <= '0;
      tx_reg      <= '0;
      addr_reg    <= '0;
      oe_reg      <= 1'b0;
      ack_reg     <= 1'b0;
      flush_reg   <= 1'b0;
      sda_out_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      shift_reg   <= shift_next;
      tx_reg      <= tx_next;
      addr_reg    <= addr_next;
      oe_reg      <= oe_next;
      ack_reg     <= ack_next;
      flush_reg   <= flush_next;
      sda_out_reg <= 1'b0;
    end
  end

  assign o_sda_oe  = oe_reg;
  assign o_sda_out = sda_out_reg;

  // ************************************
  // prefetch from array into fifo
  // ************************************
  addr_t fetch_reg;
  addr_t fetch_next;
  logic  rd_reg;
  logic  rd_next;
  logic  pend_reg;
  logic  pend_next;

  assign fq.flush     = flush_reg;
  assign fq.in_valid  = pend_reg && !flush_reg;
  assign fq.in_data   = i_mem_data;
  assign fq.out_ready = pop;

  always_comb begin
    rd_next    = !flush_reg && !rd_reg && !pend_reg && fq.in_ready;
    pend_next  = rd_reg && !flush_reg;
    fetch_next = fetch_reg;
    if (flush_reg) begin
      fetch_next = addr_reg;
    end else if (fq.in_valid && fq.in_ready) begin
      fetch_next = addr_t'(fetch_reg + `ADDR_ONE);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fetch_reg <= '0;
      rd_reg    <= 1'b0;
      pend_reg  <= 1'b0;
    end else begin
      fetch_reg <= fetch_next;
      rd_reg    <= rd_next;
      pend_reg  <= pend_next;
    end
  end

  assign o_mem_addr = fetch_reg;
  assign o_mem_rd   = rd_reg;

  byte_fifo #(.WIDTH(`DATA_BITS), .DEPTH(`FIFO_WORDS)) u_fifo (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .port      (fq.fifo)
  );

  // ************************************
  // assertions
  // ************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  logic byte_done;
  assign byte_done = scl_fall && !start && !stop && cnt_reg == `BYTE_BITS;

  read_addr_ack_a: assert property (
    byte_done && state_reg == ST_DEV && shift_reg[0]
    && dev_match(shift_reg, cs_s, `DEV_PREAMBLE) |=> oe_reg && state_reg == ST_RACK)
    else $error("read address not acknowledged");
  perm_query_a: assert property (
    byte_done && state_reg == ST_DEV && shift_reg[0]
    && dev_match(shift_reg, cs_s, `PERM_QUERY_PRE) |=> oe_reg == !$past(i_permanent_protect_flag))
    else $error("permanent query answer wrong");
  rev_query_a: assert property (
    byte_done && state_reg == ST_DEV && shift_reg[0]
    && dev_match(shift_reg, cs_s, `REV_QUERY_PRE) |=> oe_reg == !$past(i_reversible_protect_flag))
    else $error("reversible query answer wrong");
  addr_step_a: assert property (
    pop |=> addr_reg == addr_t'($past(addr_reg) + `ADDR_ONE))
    else $error("counter did not step by one");
  addr_wrap_a: assert property (
    pop && addr_reg == 8'hFF |=> addr_reg == 8'h00 && state_reg == ST_TX)
    else $error("counter did not wrap to zero");
  addr_hold_a: assert property (
    state_reg == ST_IDLE && !start |=> $stable(addr_reg))
    else $error("counter changed while bus idle");
  word_load_a: assert property (
    byte_done && state_reg == ST_WORD |=> addr_reg == $past(shift_reg) && flush_reg)
    else $error("word address not loaded");
  nack_end_a: assert property (
    state_reg == ST_HACK && scl_fall && !ack_reg && !start && !stop
    |=> state_reg == ST_WAIT && !oe_reg)
    else $error("send continued after no-ack");
  first_bit_a: assert property (
    pop |=> oe_reg == !tx_reg[7] && cnt_reg == 4'h1)
    else $error("first data bit not driven");

  seq_read_c:  cover property (state_reg == ST_HACK && scl_fall && ack_reg);
  query_ack_c: cover property (state_reg == ST_QACK);
  wrap_c:      cover property (pop && addr_reg == 8'hFF);
  random_c:    cover property (flush_reg ##[1:300] pop);
endmodule

// *** src/eeprom_rd_regs.svh ***
// constants for the serial memory read engine
`ifndef EEPROM_RD_REGS_SVH
`define EEPROM_RD_REGS_SVH
`define DEV_PREAMBLE   4'hA
`define PERM_QUERY_PRE 4'h6
`define REV_QUERY_PRE  4'h7
`define BYTE_BITS      4'h8
`define BIT_TOP        4'h7
`define ADDR_ONE       8'h01
`define IDLE_BYTE      8'hFF
`define FIFO_WORDS     4
`define DATA_BITS      8
`endif

// *** src/eeprom_rd_pkg.sv ***
// types for the serial memory read engine
package eeprom_rd_pkg;
  typedef logic [7:0] addr_t;
  typedef logic [7:0] byte_t;
  typedef logic [2:0] cs_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_DEV, ST_WACK, ST_WORD, ST_DACK, ST_WDATA,
    ST_QACK, ST_RACK, ST_TX, ST_HACK, ST_WAIT
  } state_e;
endpackage

// *** src/byte_fifo_if.sv ***
// fifo carrier between the read engine and its prefetch buffer
`timescale 1ns/1ps
interface byte_fifo_if #(parameter int WIDTH = 8);
  logic             flush;
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;
  modport fifo (input flush, in_valid, in_data, out_ready,
                output in_ready, out_valid, out_data);
  modport user (output flush, in_valid, in_data, out_ready,
                input in_ready, out_valid, out_data);
endinterface

// *** src/byte_fifo.sv ***
// small prefetch fifo with flush
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_reset_n,
  // fifo ports
  byte_fifo_if.fifo port
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_reg;
  logic [PW-1:0]    wr_next;
  logic [PW-1:0]    rd_reg;
  logic [PW-1:0]    rd_next;
  logic [PW:0]      cnt_reg;
  logic [PW:0]      cnt_next;
  logic             push;
  logic             pop;

  assign port.in_ready  = (cnt_reg != (PW+1)'(DEPTH));
  assign port.out_valid = (cnt_reg != '0);
  assign port.out_data  = mem_reg[rd_reg];
  assign push = port.in_valid && port.in_ready;
  assign pop  = port.out_ready && port.out_valid;

  always_comb begin
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (port.flush) begin
      wr_next  = '0;
      rd_next  = '0;
      cnt_next = '0;
    end else begin
      if (push) begin
        wr_next = PW'(wr_reg + 1'b1);
      end
      if (pop) begin
        rd_next = PW'(rd_reg + 1'b1);
      end
      cnt_next = (PW+1)'(cnt_reg + (PW+1)'(push) - (PW+1)'(pop));
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (push && !port.flush) begin
      mem_reg[wr_reg] <= port.in_data;
    end
  end
endmodule

// *** sim/two_wire_host_model.sv ***
// behavioural two-wire bus master driving the serial memory pins
`timescale 1ns/1ps
module two_wire_host_model (
  // wired data line
  input  wire logic i_sda_line,
  // bus pins, high means released
  output logic      o_scl,
  output logic      o_sda
);
  // ****************************************
  // bus conditions
  // ****************************************
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // start or repeated start
  task automatic bus_start();
    o_sda = 1'b1;
    #31.25;
    o_scl = 1'b1;
    #31.25;
    o_sda = 1'b0;
    #31.25;
    o_scl = 1'b0;
    #31.25;
  endtask

  task automatic bus_stop();
    o_sda = 1'b0;
    #31.25;
    o_scl = 1'b1;
    #31.25;
    o_sda = 1'b1;
    #62.5;
  endtask

  // ****************************************
  // bits and bytes
  // ****************************************
  // one bit, data set mid low phase, sampled mid high phase
  task automatic bus_bit(input logic b, output logic r);
    o_sda = b;
    #31.25;
    o_scl = 1'b1;
    #31.25;
    r = i_sda_line;
    #31.25;
    o_scl = 1'b0;
    #31.25;
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bus_bit(b[i], r);
    end
    bus_bit(1'b1, r);
    ack = ~r;
  endtask

  // receive a byte, then ack to go on or nack to finish
  task automatic get_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bus_bit(1'b1, d[i]);
    end
    bus_bit(~more, r);
  endtask
endmodule

// *** sim/serial_eeprom_read_engine_bench.sv ***
// self-checking bench for the serial memory read engine
`timescale 1ns/1ps
`define check_eq(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end
module serial_eeprom_read_engine_bench;
  import eeprom_rd_pkg::*;
  // ****************************************
  // clock, pins and models
  // ****************************************
  logic  clk        = 1'b0;
  logic  rst_n      = 1'b0;
  logic  perm_flag  = 1'b0;
  logic  rev_flag   = 1'b0;
  cs_t   cs_pins    = 3'b101;
  byte_t mem_data   = 8'h00;
  byte_t exp_ctr    = 8'h00;
  int    checks     = 0;
  int    mismatches = 0;
  logic  scl;
  logic  sda_m;
  logic  sda_oe;
  logic  sda_out;
  logic  mem_rd;
  addr_t mem_addr;
  wire   sda_line = sda_oe ? (sda_out & sda_m) : sda_m;

  always #5 clk = ~clk;

  // array model, data one cycle after the read pulse
  always @(posedge clk) begin
    if (mem_rd === 1'b1) begin
      mem_data <= mem_addr ^ 8'h3C;
    end
  end

  serial_eeprom_read_engine serial_eeprom_read_engine_i (
    .i_ref_clk                 (clk),
    .i_reset_n                 (rst_n),
    .i_scl                     (scl),
    .i_sda                     (sda_line),
    .o_sda_out                 (sda_out),
    .o_sda_oe                  (sda_oe),
    .i_chip_select_bit2        (cs_pins[2]),
    .i_chip_select_bit1        (cs_pins[1]),
    .i_chip_select_bit0        (cs_pins[0]),
    .i_permanent_protect_flag  (perm_flag),
    .i_reversible_protect_flag (rev_flag),
    .o_mem_addr                (mem_addr),
    .o_mem_rd                  (mem_rd),
    .i_mem_data                (mem_data)
  );

  two_wire_host_model two_wire_host_model_i (
    .i_sda_line (sda_line),
    .o_scl      (scl),
    .o_sda      (sda_m)
  );

  // ****************************************
  // helpers
  // ****************************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    exp_ctr = 8'h00;
  endtask

  // read n bytes, random reads first load the word address
  task automatic seq_read(input logic random, input byte_t a, input int n);
    logic  ack;
    byte_t d;
    two_wire_host_model_i.bus_start();
    if (random) begin
      two_wire_host_model_i.send_byte({4'hA, cs_pins, 1'b0}, ack);
      `check_eq(ack, 1'b1)
      two_wire_host_model_i.send_byte(a, ack);
      `check_eq(ack, 1'b1)
      two_wire_host_model_i.bus_start();
    end
    two_wire_host_model_i.send_byte({4'hA, cs_pins, 1'b1}, ack);
    `check_eq(ack, 1'b1)
    for (int i = 0; i < n; i++) begin
      two_wire_host_model_i.get_byte(i < n - 1, d);
      `check_eq(d, byte_t'(a + i) ^ 8'h3C)
    end
    two_wire_host_model_i.bus_stop();
    exp_ctr = byte_t'(a + n);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // outputs looked at while reset is still held
  task automatic scen_reset_state();
    `check_eq(sda_oe, 1'b0)
    `check_eq(sda_out, 1'b0)
    `check_eq(mem_rd, 1'b0)
    `check_eq(mem_addr, 8'h00)
  endtask

  task automatic scen_random();
    seq_read(1'b1, 8'h10, 1);
    // resumes at last address plus one
    seq_read(1'b0, 8'h11, 1);
  endtask

  task automatic scen_current();
    seq_read(1'b0, exp_ctr, 2);
    seq_read(1'b0, exp_ctr, 1);
  endtask

  task automatic scen_wrap();
    seq_read(1'b1, 8'hFE, 4);
    seq_read(1'b0, exp_ctr, 1);
  endtask

  task automatic scen_query();
    logic ack;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      perm_flag <= k[0];
      rev_flag  <= k[1];
      repeat (2) @(posedge clk);
      two_wire_host_model_i.bus_start();
      two_wire_host_model_i.send_byte({4'h6, cs_pins, 1'b1}, ack);
      two_wire_host_model_i.bus_stop();
      `check_eq(ack, ~k[0])
      two_wire_host_model_i.bus_start();
      two_wire_host_model_i.send_byte({4'h7, cs_pins, 1'b1}, ack);
      two_wire_host_model_i.bus_stop();
      `check_eq(ack, ~k[1])
    end
    two_wire_host_model_i.bus_start();
    two_wire_host_model_i.send_byte({4'h6, cs_pins, 1'b0}, ack);
    two_wire_host_model_i.bus_stop();
    `check_eq(ack, 1'b0)
    seq_read(1'b0, exp_ctr, 1);
  endtask

  task automatic scen_foreign();
    logic ack;
    @(posedge clk);
    cs_pins <= 3'b010;
    repeat (4) @(posedge clk);
    two_wire_host_model_i.bus_start();
    two_wire_host_model_i.send_byte({4'hA, 3'b101, 1'b1}, ack);
    two_wire_host_model_i.bus_stop();
    `check_eq(ack, 1'b0)
    seq_read(1'b0, exp_ctr, 2);
    @(posedge clk);
    cs_pins <= 3'b101;
    repeat (4) @(posedge clk);
  endtask

  task automatic scen_second_reset();
    do_reset();
    seq_read(1'b0, exp_ctr, 1);
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    close_out();
  end

  initial begin
    repeat (6) @(posedge clk);
    scen_reset_state();
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    scen_random();
    scen_current();
    scen_wrap();
    scen_query();
    scen_foreign();
    scen_second_reset();
    close_out();
  end
endmodule
